// *** logic/arf_format.sv ***
`timescale 1ns/1ns
module arf_format
  import arf_pkg::*;
#(
  parameter logic [7:0] TEMP_GAIN_VALUE = 8'h80,  // Arbitrary factory value
  parameter logic [7:0] TEMP_OFFSET_VALUE = 8'h00 // Arbitrary factory value
) (
  input wire logic clk_sys,                  // 250 MHz system clock
  input wire logic rst,                      // Synchronous reset, high
  input wire arf_conv_type conv_in,          // Core result and done pulse
  input wire logic [4:0] channel_select_field, // Channel and gain code
  input wire logic bipolar_mode_select,      // One selects bipolar mode on differential codes
  input wire logic left_adjust_bit,          // One left-justifies result
  input wire logic ref_select_hi,            // Reference select bit 1
  input wire logic ref_select_lo,            // Reference select bit 0
  input wire logic ref_output_enable,        // Reference pin output enable
  input wire logic conv_enable,              // Converter switched on
  input wire logic sig_read_req,             // Signature read strobe
  input wire logic [15:0] sig_addr,          // Signature row address
  output arf_result_type result,             // Result byte pair
  output logic conv_done_flag,               // Sticky completion flag
  input wire logic conv_done_clear,          // Clears completion flag
  output logic result_sign_bit,              // Polarity in bipolar mode
  output logic [7:0] sig_data,               // Signature byte read back
  output logic sig_valid,                    // Signature data valid pulse
  output logic ref_out_1v1,                  // Drive 1.1V on reference pin
  output logic ref_out_2v56,                 // Drive 2.56V on reference pin
  output logic ref_output_pin_oe             // Reference pin is driven
);

  ////////////////////////////////////////////////////////////////////////
  // Captured formatted code; left adjust acts on this live, so it can change
  // the presented bytes without waiting for a new conversion.
  // Mode inputs are read live at the completion edge; software that moves
  // them during a conversion gets the new view of the old sample.
  // The core value is only meaningful in the cycle done is high, so the
  // hold path below never looks at it otherwise.
  // Limitation: gain is applied in the analog core; this block only sees
  // the already scaled difference and formats it.
  // Reset gives an all-zero pair and a clear flag, as after power-up.
  logic [9:0] code;
  logic [9:0] next_code;
  logic done_flag;
  logic next_done_flag;
  arf_mode_type mode;

  // Mode decode from channel code and bipolar bit. Codes below the first
  // differential pair are single ended and ignore the bipolar bit;
  // differential pairs stay unipolar until software asks otherwise.
  always_comb begin
    if (channel_select_field < DIFF_MIN_CODE) begin
      mode = ARF_SINGLE;
    end else if (bipolar_mode_select) begin
      mode = ARF_BIPOLAR;
    end else begin
      mode = ARF_UNIPOLAR;
    end
  end

  // Format a completed conversion; hold otherwise
  always_comb begin
    next_code = code;
    if (conv_in.done) begin
      case (mode)
        ARF_SINGLE: begin
          // Top bit set means below ground; clamp to the bottom code
          if (conv_in.value[10]) begin
            next_code = CODE_ZERO;
          end else begin
            next_code = conv_in.value[9:0];
          end
        end
        ARF_UNIPOLAR: begin
          // Negative difference saturates to zero; gain is the core's job
          if (conv_in.value[10]) begin
            next_code = CODE_ZERO;
          end else begin
            next_code = conv_in.value[9:0];
          end
        end
        ARF_BIPOLAR: begin
          // Halve scale to 512 and saturate into 10-bit two's complement
          // Dropping the low bit trades one step of resolution for sign
          if ($signed(conv_in.value[10:1]) > $signed(BIP_MAX)) begin
            next_code = BIP_MAX;
          end else begin
            next_code = conv_in.value[10:1];
          end
        end
        default: begin
          next_code = code;
        end
      endcase
    end
  end

  // Done flag: a new completion beats a clear in the same cycle, so a
  // result that lands while software clears the old one is never lost.
  // The flag is sticky until software or reset clears it; nothing else drops it.
  always_comb begin
    next_done_flag = done_flag;
    if (conv_done_clear) begin
      next_done_flag = 1'b0;
    end
    if (conv_in.done) begin
      next_done_flag = 1'b1;
    end
  end

  // Code and flag state registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      code <= CODE_ZERO;
      done_flag <= 1'b0;
    end else begin
      code <= next_code;
      done_flag <= next_done_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output registers for result pair and sign. They are fed from the
  // next code, not the stored one, so the pair is already valid in the
  // cycle the done flag first reads high; a second register stage would
  // let software read a stale pair right after the flag rises.
  arf_result_type next_result;
  logic next_sign;
  always_comb begin
    if (left_adjust_bit) begin
      next_result = {next_code, PAD6};
    end else begin
      next_result = {PAD6, next_code};
    end
    // Polarity only means something in bipolar mode; elsewhere it reads 0
    next_sign = (mode == ARF_BIPOLAR) && next_code[SIGN_POS];
  end

  // Result, sign and flag flops; flag and pair move on the same edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result <= '0;
      result_sign_bit <= 1'b0;
      conv_done_flag <= 1'b0;
    end else begin
      result <= next_result;
      result_sign_bit <= next_sign;
      conv_done_flag <= next_done_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Signature row: calibration bytes, zero for other addresses. Only the
  // two temperature bytes are modelled; the rest of the row reads zero.
  logic [7:0] next_sig_data;
  logic next_sig_valid;
  always_comb begin
    next_sig_data = sig_data;
    next_sig_valid = sig_read_req; // One-cycle answer per strobe
    if (sig_read_req) begin
      if (sig_addr == SIG_ADDR_TEMP_GAIN) begin
        next_sig_data = TEMP_GAIN_VALUE;
      end else if (sig_addr == SIG_ADDR_TEMP_OFFSET) begin
        next_sig_data = TEMP_OFFSET_VALUE;
      end else begin
        next_sig_data = 8'h00;
      end
    end
  end

  // Signature flops; data holds between reads so a slow reader still
  // finds it, while valid marks the single answering cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sig_data <= 8'h00;
      sig_valid <= 1'b0;
    end else begin
      sig_data <= next_sig_data;
      sig_valid <= next_sig_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference output pin; other selections leave the pin undriven.
  // The pin only carries a level; the analog buffer behind it takes the
  // two drive selects and the enable straight from these flops.
  logic next_1v1;
  logic next_2v56;
  logic next_oe;
  always_comb begin
    next_1v1 = 1'b0;
    next_2v56 = 1'b0;
    if (ref_output_enable && conv_enable) begin
      case ({ref_select_hi, ref_select_lo})
        REF_SEL_INT_1V1: begin
          next_1v1 = 1'b1;
        end
        REF_SEL_INT_2V56: begin
          next_2v56 = 1'b1;
        end
        default: begin
          // Supply or external reference: nothing internal to show
          next_1v1 = 1'b0;
        end
      endcase
    end
    // Enable low or converter off keeps the pin free for other uses
    next_oe = next_1v1 || next_2v56;
  end

  // Reference pin flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ref_out_1v1 <= 1'b0;
      ref_out_2v56 <= 1'b0;
      ref_output_pin_oe <= 1'b0;
    end else begin
      ref_out_1v1 <= next_1v1;
      ref_out_2v56 <= next_2v56;
      ref_output_pin_oe <= next_oe;
    end
  end

endmodule

// *** common/arf_pkg.sv ***
package arf_pkg;
  localparam int RES_W = 10;
  localparam logic [15:0] SIG_ADDR_TEMP_GAIN = 16'h0007;
  localparam logic [15:0] SIG_ADDR_TEMP_OFFSET = 16'h0005;
  localparam logic [1:0] REF_SEL_INT_1V1 = 2'h1;
  localparam logic [1:0] REF_SEL_INT_2V56 = 2'h3;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] CODE_MAX = 10'h3ff;
  localparam logic [9:0] BIP_MIN = 10'h200;
  localparam logic [9:0] BIP_MAX = 10'h1ff;
  localparam int SIGN_POS = 9;
  localparam logic [4:0] DIFF_MIN_CODE = 5'h10;
  localparam logic [4:0] TEMP_SENSOR_CODE = 5'h0b;
  localparam logic [5:0] PAD6 = 6'h00;

  // Raw conversion from the analog core: signed difference, 11 bits
  typedef struct packed {
    logic done;
    logic [10:0] value;
  } arf_conv_type;

  // Presented result byte pair
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } arf_result_type;

  typedef enum logic [1:0] {
    ARF_SINGLE,
    ARF_UNIPOLAR,
    ARF_BIPOLAR
  } arf_mode_type;
endpackage

// *** tb/arf_monitor.sv ***
`timescale 1ns/1ns
module arf_monitor
  import arf_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire arf_conv_type conv_in, // Core word
  input wire logic [4:0] channel_select_field, // Channel
  input wire logic bipolar_mode_select, // Bipolar
  input wire logic left_adjust_bit, // Justify
  input wire logic ref_output_enable, // Ref enable
  input wire arf_result_type result, // Result pair
  input wire logic conv_done_flag, // Done flag
  input wire logic conv_done_clear, // Flag clear
  input wire logic result_sign_bit, // Sign
  input wire logic ref_output_pin_oe // Pin driven
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A completion with a non-negative single-ended code
  sequence s_pos; conv_in.done && !conv_in.value[10]; endsequence
  sequence s_se; s_pos ##0 channel_select_field < DIFF_MIN_CODE; endsequence
  property p_flag; conv_in.done |=> conv_done_flag; endproperty
  a_flag: assert property (p_flag) else $error("flag late");
  property p_right; s_se ##0 !left_adjust_bit
    |=> result == {6'h00, $past(conv_in.value[9:0])}; endproperty
  a_right: assert property (p_right) else $error("right code");
  property p_left; s_se ##0 left_adjust_bit
    |=> result == {$past(conv_in.value[9:0]), 6'h00}; endproperty
  a_left: assert property (p_left) else $error("left code");
  property p_clamp; conv_in.done && conv_in.value[10] && !bipolar_mode_select
    |=> result == 16'h0000; endproperty
  a_clamp: assert property (p_clamp) else $error("no clamp");
  property p_bip; conv_in.done && bipolar_mode_select && !left_adjust_bit
    && channel_select_field >= DIFF_MIN_CODE
    |=> {result.high[1:0], result.low} == $past(conv_in.value[10:1]);
  endproperty
  a_bip: assert property (p_bip) else $error("bipolar code");
  property p_sign; !$past(bipolar_mode_select) |-> !result_sign_bit;
  endproperty
  a_sign: assert property (p_sign) else $error("sign");
  property p_clr; conv_done_clear && !conv_in.done |=> !conv_done_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("clear");
  // Without a completion or a view change the pair must not move
  property p_hold; !conv_in.done && $stable(left_adjust_bit)
    && $stable(bipolar_mode_select) && $stable(channel_select_field)
    |=> $stable(result); endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_oe; !ref_output_enable |=> !ref_output_pin_oe; endproperty
  a_oe: assert property (p_oe) else $error("pin driven");
endmodule

bind arf_format arf_monitor arf_monitor_inst (.clk_sys, .rst, .conv_in,
  .channel_select_field, .bipolar_mode_select, .left_adjust_bit,
  .ref_output_enable, .result, .conv_done_flag, .conv_done_clear,
  .result_sign_bit, .ref_output_pin_oe);

// *** tb/arf_core_model.sv ***
`timescale 1ns/1ns
module arf_core_model
  import arf_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic start, // Start strobe
  input wire logic [10:0] sample, // Code to return
  output arf_conv_type conv // To the block
);
  // Value is qualified by done only; off-pulse it toggles to expose misuse
  always @(posedge clk_sys) begin
    conv.done <= start;
    conv.value <= start ? sample : ~conv.value;
  end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  import arf_pkg::*;
  logic clk_sys = 0, rst = 1, start = 0, bipolar_mode_select = 0;
  logic left_adjust_bit = 0, ref_select_hi = 0, ref_select_lo = 0;
  logic ref_output_enable = 0, conv_enable = 0, sig_read_req = 0;
  logic conv_done_clear = 0, conv_done_flag, result_sign_bit, sig_valid;
  logic ref_out_1v1, ref_out_2v56, ref_output_pin_oe;
  logic [4:0] channel_select_field = 5'h00;
  logic [10:0] sample = 11'h000;
  logic [15:0] sig_addr = 16'h0000;
  logic [7:0] sig_data;
  arf_conv_type conv_in;
  arf_result_type result;
  int err_total = 0, cmp_count = 0, cyc = 0;
  arf_core_model arf_core_model_inst (.clk_sys, .start, .sample,
    .conv(conv_in));
  arf_format #(
    .TEMP_GAIN_VALUE(8'h80),
    .TEMP_OFFSET_VALUE(8'hf6)
  ) arf_format_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .conv_in(conv_in),
    .channel_select_field(channel_select_field),
    .bipolar_mode_select(bipolar_mode_select),
    .left_adjust_bit(left_adjust_bit),
    .ref_select_hi(ref_select_hi),
    .ref_select_lo(ref_select_lo),
    .ref_output_enable(ref_output_enable),
    .conv_enable(conv_enable),
    .sig_read_req(sig_read_req),
    .sig_addr(sig_addr),
    .result(result),
    .conv_done_flag(conv_done_flag),
    .conv_done_clear(conv_done_clear),
    .result_sign_bit(result_sign_bit),
    .sig_data(sig_data),
    .sig_valid(sig_valid),
    .ref_out_1v1(ref_out_1v1),
    .ref_out_2v56(ref_out_2v56),
    .ref_output_pin_oe(ref_output_pin_oe)
  );
  initial forever #2 clk_sys = ~clk_sys;
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One conversion: settings ride with the start strobe, checked after
  task automatic conv(input logic [4:0] ch, input logic b, l,
      input logic [10:0] v, input logic [16:0] e);
    @(posedge clk_sys);
    {channel_select_field, bipolar_mode_select, left_adjust_bit} <= {ch, b, l};
    sample <= v;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({result_sign_bit, result}, e);
    chk(conv_done_flag, 1'b1);
  endtask
  // Signature read: the previous answer must be gone before asking again
  task automatic sig(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    sig_addr <= a;
    sig_read_req <= 1'b1;
    #1;
    chk(sig_valid, 1'b0);
    @(posedge clk_sys);
    sig_read_req <= 1'b0;
    #1;
    chk({sig_valid, sig_data}, {1'b1, e});
  endtask
  task automatic refc(input logic [3:0] s, input logic [2:0] e);
    @(posedge clk_sys);
    {ref_output_enable, conv_enable, ref_select_hi, ref_select_lo} <= s;
    @(posedge clk_sys);
    #1;
    chk({ref_out_1v1, ref_out_2v56, ref_output_pin_oe}, e);
  endtask
  // Clear the flag, then flip justification with no new conversion
  task automatic t_hold;
    @(posedge clk_sys);
    conv_done_clear <= 1'b1;
    @(posedge clk_sys);
    conv_done_clear <= 1'b0;
    left_adjust_bit <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({conv_done_flag, result}, 17'h07fc0);
    $display("hold test done");
  endtask
  // Completion and clear in one cycle: the completion must win
  task automatic t_race;
    @(posedge clk_sys);
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    conv_done_clear <= 1'b1;
    @(posedge clk_sys);
    conv_done_clear <= 1'b0;
    #1;
    chk(conv_done_flag, 1'b1);
    $display("race test done");
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Cut a hang short; the whole run needs about 60 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    {ref_select_hi, ref_select_lo} <= REF_SEL_INT_1V1;
    #1;
    chk({result_sign_bit, result, conv_done_flag}, 18'h0);
    conv(5'h0b, 1'b0, 1'b0, 11'h3ff, 17'h003ff);
    conv(5'h00, 1'b0, 1'b1, 11'h2c5, 17'h0b140);
    conv(5'h10, 1'b0, 1'b0, 11'h7ff, 17'h00000);
    conv(5'h11, 1'b0, 1'b0, 11'h3ff, 17'h003ff);
    conv(5'h1f, 1'b1, 1'b0, 11'h400, 17'h10200);
    conv(5'h1e, 1'b1, 1'b0, 11'h3fe, 17'h001ff);
    $display("conversion tests done");
    t_hold();
    t_race();
    sig(SIG_ADDR_TEMP_GAIN, 8'h80);
    sig(SIG_ADDR_TEMP_OFFSET, 8'hf6);
    sig(16'h0006, 8'h00);
    $display("signature tests done");
    refc(4'h5, 3'h0);
    refc(4'hd, 3'h5);
    refc(4'hf, 3'h3);
    refc(4'hb, 3'h0);
    $display("reference tests done");
    test_done();
  end
endmodule
